// [ppp_defs.vh]
// ppp_defs.vh - constants for the parallel programming port
// assumes inclusion by bare name from design files of the same folder
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH

// ==========================================================
// action select codes (action_select_hi, action_select_lo)
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3

// ==========================================================
// command bytes
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_PROG 8'h10
`define PPP_CMD_WR_DATA 8'h11
`define PPP_CMD_RD_ID 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_PROG 8'h02
`define PPP_CMD_RD_DATA 8'h03

// ==========================================================
// memory geometry
`define PPP_PROG_AW 10
`define PPP_PROG_WORD_BITS 4
`define PPP_PROG_PAGE_WORDS 16
`define PPP_DATA_AW 7
`define PPP_DATA_WORD_BITS 2
`define PPP_DATA_PAGE_BYTES 4
`define PPP_ERASED_BYTE 8'hFF

// ==========================================================
// fuse and lock layout, reset values
`define PPP_FUSE_LO_RST 8'hFF
`define PPP_FUSE_HI_RST 8'hFF
`define PPP_FUSE_EX_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
`define PPP_PRESERVE_BIT 6
`define PPP_LOCK_ONE_BIT 0
`define PPP_LOCK_TWO_BIT 1
// boot lock bits sit above the two mode bits
`define PPP_BOOT_LOCK_MASK 8'h3C

// ==========================================================
// timing
`define PPP_CLK_MHZ 100
`define PPP_T_WRITE_US 3700
`define PPP_T_ERASE_US 7500
`define PPP_WRITE_CYC (`PPP_T_WRITE_US * `PPP_CLK_MHZ)
`define PPP_ERASE_CYC (`PPP_T_ERASE_US * `PPP_CLK_MHZ)

`endif

// [ppp_mem.v]
// ppp_mem.v - single port memory with registered read data
// assumes one write or one read per cycle; erase is done by the owner word by word
`timescale 1ns/1ps
module ppp_mem #(
   parameter AW = 10,
   parameter DW = 16
) (
   input wire sys_clk_i,
   input wire we_i,
   input wire [AW-1:0] addr_i,
   input wire [DW-1:0] wdata_i,
   output reg [DW-1:0] rdata_o
);
   reg [DW-1:0] mem_r [0:(1<<AW)-1];

   always @(posedge sys_clk_i) begin
      if (we_i) begin
         mem_r[addr_i] <= wdata_i;
      end
      rdata_o <= mem_r[addr_i];
   end
endmodule // ppp_mem

// [ppp_port.v]
// ppp_port.v - parallel programming port for program, data, fuse, lock and id bytes
// assumes the programmer pins are already synchronous to sys_clk_i and programming
// mode has been entered; the bidirectional bus is split into in, out and enable.
// How it works
// RULE1 - command and address latches hold until the programmer reloads them
// RULE2 - high address byte persists across operations until explicitly reloaded
// RULE3 - erase clears program, data and locks; locks released after program erase
// RULE4 - preserve fuse programmed keeps data memory intact during erase
// RULE5 - action 10 with strobe loads command; 1000 0000 is full erase
// RULE6 - write pulse after erase starts it, ready/busy low until finished
// RULE7 - 0001 0000 writes program memory through a whole-page buffer
// RULE8 - action 00 strobe loads address byte, byte select one picks half
// RULE9 - action 01 strobe loads data byte, low then high per word
// RULE10 - low address bits pick word in page, upper bits pick page
// RULE11 - write pulse programs whole program page, busy until done
// RULE12 - command 0000 0000 ends page programming and resets write control
// RULE13 - 0001 0001 writes data page on write pulse with byte select low
// RULE14 - 0000 0010 with output enable low reads program word byte
// RULE15 - 0000 0011 with output enable low reads data memory byte
// RULE16 - 0100 0000 writes low, high or extended fuses from low data
// RULE17 - 0010 0000 programs lock zeros; mode 3 refuses boot lock changes
// RULE18 - lock bits return unprogrammed only via full erase
// RULE19 - 0000 0100 reads fuses or locks chosen by the byte select pair
// RULE20 - 0000 1000 reads id byte at low address 0 to 2
// RULE21 - id read at address 0 with byte select one high gives calibration
// RULE22 - programmer may skip writing 0xFF after erase unless data preserved
// RULE23 - ready/busy low while an operation runs, high when ready
// RULE24 - action 11 makes strobes do nothing
`timescale 1ns/1ps
`include "ppp_defs.vh"
module ppp_port #(
   parameter [31:0] WRITE_CYC = `PPP_WRITE_CYC,
   parameter [31:0] ERASE_CYC = `PPP_ERASE_CYC,
   parameter [7:0] ID_BYTE0 = 8'h5A, // arbitrary identity value
   parameter [7:0] ID_BYTE1 = 8'h3C, // arbitrary identity value
   parameter [7:0] ID_BYTE2 = 8'hC3, // arbitrary identity value
   parameter [7:0] CAL_BYTE = 8'h80
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire load_strobe_clock_in_i,
   input wire action_select_hi_i,
   input wire action_select_lo_i,
   input wire byte_select_one_i,
   input wire byte_select_two_i,
   input wire write_n_i,
   input wire output_enable_n_i,
   input wire [7:0] data_i,
   output reg [7:0] data_o,
   output wire data_oe_o,
   output wire ready_busy_out_o,
   output wire [7:0] fuse_lo_o,
   output wire [7:0] fuse_hi_o,
   output wire [7:0] fuse_ex_o,
   output wire [7:0] lock_o
);
   // ==========================================================
   // states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_PROG_PAGE = 3'h1;
   localparam [2:0] ST_DATA_PAGE = 3'h2;
   localparam [2:0] ST_ERASE_PROG = 3'h3;
   localparam [2:0] ST_ERASE_DATA = 3'h4;
   localparam [2:0] ST_WAIT = 3'h5;

   localparam [9:0] PROG_LAST = 10'h3FF;
   localparam [6:0] DATA_LAST = 7'h7F;
   // page walk end: one cycle per program buffer entry, the data walk wraps over its 4 entries; the write time must exceed it
   localparam [9:0] PAGE_DONE = 10'h010;

   reg [7:0] cmd_r;
   reg [7:0] addr_lo_r;
   reg [7:0] addr_hi_r;
   reg [7:0] dat_lo_r;
   reg [7:0] fuse_lo_r;
   reg [7:0] fuse_hi_r;
   reg [7:0] fuse_ex_r;
   reg [7:0] lock_r;
   reg [2:0] state_r;
   reg [31:0] timer_r;
   reg [9:0] walk_r;
   reg xstb_d_r;
   reg wr_d_r;
   reg page_armed_r;
   reg [15:0] pbuf_r [0:`PPP_PROG_PAGE_WORDS-1];
   reg [7:0] dbuf_r [0:`PPP_DATA_PAGE_BYTES-1];
   reg [`PPP_PROG_PAGE_WORDS-1:0] pvalid_r;
   reg [`PPP_DATA_PAGE_BYTES-1:0] dvalid_r;

   wire [1:0] act = {action_select_hi_i, action_select_lo_i};
   wire xstb_rise = load_strobe_clock_in_i & ~xstb_d_r;
   wire wr_fall = ~write_n_i & wr_d_r;
   wire busy = (state_r != ST_IDLE);
   wire [15:0] full_addr = {addr_hi_r, addr_lo_r};
   wire [`PPP_PROG_WORD_BITS-1:0] pword = addr_lo_r[`PPP_PROG_WORD_BITS-1:0];
   wire [`PPP_DATA_WORD_BITS-1:0] dword = addr_lo_r[`PPP_DATA_WORD_BITS-1:0];
   wire preserve = ~fuse_hi_r[`PPP_PRESERVE_BIT];
   wire lock_mode3 = ~lock_r[`PPP_LOCK_ONE_BIT] & ~lock_r[`PPP_LOCK_TWO_BIT];

   assign ready_busy_out_o = ~busy; // RULE23
   assign fuse_lo_o = fuse_lo_r;
   assign fuse_hi_o = fuse_hi_r;
   assign fuse_ex_o = fuse_ex_r;
   assign lock_o = lock_r;

   // ==========================================================
   // memories: the walk index addresses them during page writes and erase
   reg pm_we;
   reg [9:0] pm_addr;
   reg [15:0] pm_wdata;
   reg dm_we;
   reg [6:0] dm_addr;
   reg [7:0] dm_wdata;
   wire [15:0] pm_rdata;
   wire [7:0] dm_rdata;

   always @* begin
      pm_we = 1'b0;
      pm_addr = full_addr[9:0];
      pm_wdata = 16'hFFFF;
      dm_we = 1'b0;
      dm_addr = full_addr[6:0];
      dm_wdata = `PPP_ERASED_BYTE;
      case (state_r)
         ST_PROG_PAGE: begin
            // upper low-address bits with the two low bits of the high byte select the page
            pm_addr = {full_addr[9:4], walk_r[3:0]}; // RULE10
            pm_we = pvalid_r[walk_r[3:0]];
            pm_wdata = pbuf_r[walk_r[3:0]];
         end
         ST_DATA_PAGE: begin
            dm_addr = {full_addr[6:2], walk_r[1:0]}; // RULE10
            dm_we = dvalid_r[walk_r[1:0]];
            dm_wdata = dbuf_r[walk_r[1:0]];
         end
         ST_ERASE_PROG: begin
            pm_addr = walk_r;
            pm_we = 1'b1; // RULE3
         end
         ST_ERASE_DATA: begin
            dm_addr = walk_r[6:0];
            dm_we = 1'b1; // RULE4
         end
         default: begin
            pm_we = 1'b0;
         end
      endcase
   end

   ppp_mem #(.AW(`PPP_PROG_AW), .DW(16)) u_prog (
      .sys_clk_i(sys_clk_i),
      .we_i(pm_we),
      .addr_i(pm_addr),
      .wdata_i(pm_wdata),
      .rdata_o(pm_rdata)
   );

   ppp_mem #(.AW(`PPP_DATA_AW), .DW(8)) u_data (
      .sys_clk_i(sys_clk_i),
      .we_i(dm_we),
      .addr_i(dm_addr),
      .wdata_i(dm_wdata),
      .rdata_o(dm_rdata)
   );

   // ==========================================================
   // page buffers, one generate entry per word
   genvar gi;
   generate
      for (gi = 0; gi < `PPP_PROG_PAGE_WORDS; gi = gi + 1) begin : g_pbuf
         always @(posedge sys_clk_i) begin
            if (rst_i) begin
               pbuf_r[gi] <= 16'hFFFF;
               pvalid_r[gi] <= 1'b0;
            end else if (state_r == ST_PROG_PAGE && walk_r == PAGE_DONE) begin
               pvalid_r[gi] <= 1'b0;
            end else if (xstb_rise && act == `PPP_ACT_CMD && !busy) begin
               pvalid_r[gi] <= 1'b0; // RULE12
            end else if (xstb_rise && act == `PPP_ACT_DATA && !busy &&
                         cmd_r == `PPP_CMD_WR_PROG && pword == gi) begin
               // low byte first; the high byte completes the word
               if (byte_select_one_i) begin
                  pbuf_r[gi] <= {data_i, dat_lo_r}; // RULE7 RULE9
                  pvalid_r[gi] <= 1'b1;
               end
            end
         end
      end
      for (gi = 0; gi < `PPP_DATA_PAGE_BYTES; gi = gi + 1) begin : g_dbuf
         always @(posedge sys_clk_i) begin
            if (rst_i) begin
               dbuf_r[gi] <= `PPP_ERASED_BYTE;
               dvalid_r[gi] <= 1'b0;
            end else if (state_r == ST_DATA_PAGE && walk_r == PAGE_DONE) begin
               dvalid_r[gi] <= 1'b0;
            end else if (xstb_rise && act == `PPP_ACT_CMD && !busy) begin
               dvalid_r[gi] <= 1'b0; // RULE12
            end else if (xstb_rise && act == `PPP_ACT_DATA && !busy &&
                         cmd_r == `PPP_CMD_WR_DATA && !byte_select_one_i &&
                         dword == gi) begin
               dbuf_r[gi] <= data_i; // RULE13
               dvalid_r[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // ==========================================================
   // latches and sequencer
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         cmd_r <= `PPP_CMD_NOP;
         addr_lo_r <= 8'h00;
         addr_hi_r <= 8'h00;
         dat_lo_r <= 8'h00;
         fuse_lo_r <= `PPP_FUSE_LO_RST;
         fuse_hi_r <= `PPP_FUSE_HI_RST;
         fuse_ex_r <= `PPP_FUSE_EX_RST;
         lock_r <= `PPP_LOCK_RST;
         state_r <= ST_IDLE;
         timer_r <= 32'h0000_0000;
         walk_r <= 10'h000;
         xstb_d_r <= 1'b0;
         wr_d_r <= 1'b1;
         page_armed_r <= 1'b0;
      end else begin
         xstb_d_r <= load_strobe_clock_in_i;
         wr_d_r <= write_n_i;
         // strobes are ignored while busy so latched values stay stable
         if (xstb_rise && !busy) begin
            case (act)
               `PPP_ACT_CMD: begin
                  cmd_r <= data_i; // RULE5 RULE1
                  page_armed_r <= 1'b0; // RULE12
               end
               `PPP_ACT_ADDR: begin
                  if (byte_select_one_i) begin
                     addr_hi_r <= data_i; // RULE8 RULE2
                  end else begin
                     addr_lo_r <= data_i; // RULE8
                  end
               end
               `PPP_ACT_DATA: begin
                  if (!byte_select_one_i) begin
                     dat_lo_r <= data_i; // RULE9
                     page_armed_r <= 1'b1;
                  end
               end
               default: begin
                  cmd_r <= cmd_r; // RULE24
               end
            endcase
         end
         case (state_r)
            ST_IDLE: begin
               walk_r <= 10'h000;
               if (wr_fall) begin
                  timer_r <= WRITE_CYC;
                  case (cmd_r)
                     `PPP_CMD_ERASE: begin
                        timer_r <= ERASE_CYC;
                        state_r <= ST_ERASE_PROG; // RULE6
                     end
                     `PPP_CMD_WR_PROG: begin
                        if (page_armed_r) begin
                           state_r <= ST_PROG_PAGE; // RULE11
                        end
                     end
                     `PPP_CMD_WR_DATA: begin
                        if (!byte_select_one_i && page_armed_r) begin
                           state_r <= ST_DATA_PAGE; // RULE13
                        end
                     end
                     `PPP_CMD_WR_FUSE: begin
                        state_r <= ST_WAIT;
                        if (byte_select_two_i) begin
                           fuse_ex_r <= dat_lo_r; // RULE16
                        end else if (byte_select_one_i) begin
                           fuse_hi_r <= dat_lo_r; // RULE16
                        end else begin
                           fuse_lo_r <= dat_lo_r; // RULE16
                        end
                     end
                     `PPP_CMD_WR_LOCK: begin
                        state_r <= ST_WAIT;
                        // only clears bits; setting back needs a full erase
                        if (lock_mode3) begin
                           lock_r <= lock_r & (dat_lo_r | `PPP_BOOT_LOCK_MASK); // RULE17 RULE18
                        end else begin
                           lock_r <= lock_r & dat_lo_r; // RULE17 RULE18
                        end
                     end
                     default: begin
                        state_r <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_PROG_PAGE, ST_DATA_PAGE: begin
               timer_r <= timer_r - 32'h1;
               // one buffer entry per cycle, then hold so the valid bits clear
               if (walk_r != PAGE_DONE) begin
                  walk_r <= walk_r + 10'h001;
               end
               if (timer_r <= 32'h1) begin
                  state_r <= ST_IDLE;
                  page_armed_r <= 1'b0;
               end
            end
            ST_ERASE_PROG: begin
               timer_r <= timer_r - 32'h1;
               walk_r <= walk_r + 10'h001;
               if (walk_r == PROG_LAST) begin
                  walk_r <= 10'h000;
                  lock_r <= `PPP_LOCK_RST; // RULE3
                  if (preserve) begin
                     state_r <= ST_WAIT; // RULE4
                  end else begin
                     state_r <= ST_ERASE_DATA;
                  end
               end
            end
            ST_ERASE_DATA: begin
               timer_r <= timer_r - 32'h1;
               walk_r <= walk_r + 10'h001;
               if (walk_r[6:0] == DATA_LAST) begin
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               timer_r <= timer_r - 32'h1;
               if (timer_r <= 32'h1) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // read path: data out is registered, enable follows output enable while ready/busy is high
   assign data_oe_o = ~output_enable_n_i & ~busy;

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         data_o <= 8'h00;
      end else begin
         case (cmd_r)
            `PPP_CMD_RD_PROG: begin
               data_o <= byte_select_one_i ? pm_rdata[15:8] : pm_rdata[7:0]; // RULE14
            end
            `PPP_CMD_RD_DATA: begin
               data_o <= dm_rdata; // RULE15
            end
            `PPP_CMD_RD_FUSE: begin
               case ({byte_select_two_i, byte_select_one_i})
                  2'h0: data_o <= fuse_lo_r; // RULE19
                  2'h3: data_o <= fuse_hi_r; // RULE19
                  2'h2: data_o <= fuse_ex_r; // RULE19
                  default: data_o <= lock_r; // RULE19
               endcase
            end
            `PPP_CMD_RD_ID: begin
               if (byte_select_one_i) begin
                  data_o <= (addr_lo_r == 8'h00) ? CAL_BYTE : 8'hFF; // RULE21
               end else begin
                  case (addr_lo_r)
                     8'h00: data_o <= ID_BYTE0; // RULE20
                     8'h01: data_o <= ID_BYTE1; // RULE20
                     8'h02: data_o <= ID_BYTE2; // RULE20
                     default: data_o <= 8'hFF;
                  endcase
               end
            end
            default: begin
               data_o <= 8'hFF;
            end
         endcase
      end
   end
endmodule // ppp_port

// [ppp_port_props.sv]
// ppp_port_props.sv - pin-level timing checks for the programming port
// assumes the ports of ppp_port; attached by the bind at the foot of this file
`timescale 1ns/1ps
module ppp_port_props #(
   parameter [31:0] WRITE_CYC = 40,
   parameter [31:0] ERASE_CYC = 2000
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire write_n_i,
   input wire output_enable_n_i,
   input wire data_oe_o,
   input wire ready_busy_out_o,
   input wire [7:0] fuse_lo_o,
   input wire [7:0] fuse_hi_o,
   input wire [7:0] fuse_ex_o,
   input wire [7:0] lock_o
);
   // ==========================================================
   // busy length counter
   reg [31:0] busy_cnt_r;
   always @(posedge sys_clk_i) begin
      if (rst_i || ready_busy_out_o) begin
         busy_cnt_r <= 32'h0;
      end else begin
         busy_cnt_r <= busy_cnt_r + 32'h1;
      end
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_busy8;
      !ready_busy_out_o [*8];
   endsequence
   AST_OE_ACTIVE: assert property (data_oe_o == (!output_enable_n_i && ready_busy_out_o))
      else $error("bus drive does not follow output enable");
   AST_OE_OFF: assert property (output_enable_n_i |-> !data_oe_o)
      else $error("bus driven with output enable high");
   AST_BUSY_CAUSE: assert property ($fell(ready_busy_out_o) |->
      $past(write_n_i, 2) && !$past(write_n_i))
      else $error("busy without a write pulse");
   AST_BUSY_HOLD: assert property ($fell(ready_busy_out_o) |-> s_busy8)
      else $error("busy too short");
   AST_BUSY_LEN: assert property ($rose(ready_busy_out_o) |->
      busy_cnt_r == WRITE_CYC || busy_cnt_r >= 32'd1152)
      else $error("busy length wrong");
   AST_BUSY_MAX: assert property (busy_cnt_r <= ERASE_CYC + 32'd1200)
      else $error("busy never ends");
   AST_FUSE_STABLE: assert property ($changed({fuse_lo_o, fuse_hi_o, fuse_ex_o}) |->
      !ready_busy_out_o)
      else $error("fuse changed outside an operation");
   AST_LOCK_RISE: assert property ((|(lock_o & ~$past(lock_o))) |->
      busy_cnt_r >= 32'd1024)
      else $error("lock released outside a full erase");
   AST_LOCK_MODE3: assert property ($past(lock_o[1:0]) == 2'h0 |->
      (lock_o[5:2] | ~$past(lock_o[5:2])) == 4'hF)
      else $error("boot lock changed in lock mode 3");
endmodule // ppp_port_props

bind ppp_port ppp_port_props #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) u_props (
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .write_n_i(write_n_i),
   .output_enable_n_i(output_enable_n_i),
   .data_oe_o(data_oe_o),
   .ready_busy_out_o(ready_busy_out_o),
   .fuse_lo_o(fuse_lo_o),
   .fuse_hi_o(fuse_hi_o),
   .fuse_ex_o(fuse_ex_o),
   .lock_o(lock_o)
);

// [ppp_port_tb.sv]
// ppp_port_tb.sv - self-checking bench for the programming port
// assumes ppp_defs.vh in the same folder and the programmer model beside it
`timescale 1ns/1ps
`include "ppp_defs.vh"
`define CHK(nm, e, g) \
   begin \
      check_count = check_count + 1; \
      if ((g) !== (e)) begin \
         n_errors = n_errors + 1; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end
module ppp_port_tb;
   reg sys_clk_i = 1'b0;
   reg rst_i = 1'b1;
   integer n_errors = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer i;
   wire stb, ahi, alo, b1, b2, wn, oen, oe, rdy;
   wire [7:0] bus, dout, flo, fhi, fex, lck;
   reg [7:0] v;
   reg busy;
   reg [15:0] w [0:3];
   reg [7:0] fx [0:3];
   always #5 sys_clk_i = ~sys_clk_i;

   // identity values are arbitrary; calibration keeps its default value
   ppp_port #(.WRITE_CYC(40), .ERASE_CYC(2000), .ID_BYTE0(8'h6B), .ID_BYTE1(8'h2D),
      .ID_BYTE2(8'hE1)) dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .load_strobe_clock_in_i(stb),
      .action_select_hi_i(ahi), .action_select_lo_i(alo), .byte_select_one_i(b1),
      .byte_select_two_i(b2), .write_n_i(wn), .output_enable_n_i(oen), .data_i(bus),
      .data_o(dout), .data_oe_o(oe), .ready_busy_out_o(rdy), .fuse_lo_o(flo),
      .fuse_hi_o(fhi), .fuse_ex_o(fex), .lock_o(lck));
   ppp_prog_model u_prog (
      .sys_clk_i(sys_clk_i), .ready_busy_out_i(rdy), .dev_oe_i(oe), .dev_data_i(dout),
      .strobe_o(stb), .act_hi_o(ahi), .act_lo_o(alo), .bs1_o(b1), .bs2_o(b2),
      .wr_n_o(wn), .oe_n_o(oen), .bus_o(bus));

   // ==========================================================
   // helpers and closing report
   task cmd(input [7:0] c);
      u_prog.ld(`PPP_ACT_CMD, 1'b0, c);
   endtask
   task adr(input h, input [7:0] a);
      u_prog.ld(`PPP_ACT_ADDR, h, a);
   endtask
   task dat(input h, input [7:0] d);
      u_prog.ld(`PPP_ACT_DATA, h, d);
   endtask
   task results;
      begin
         $display("checks %0d errors %0d", check_count, n_errors);
         if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         results;
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      w[0] = 16'hA55A;
      w[1] = 16'h0F0F;
      w[2] = 16'hFFFF;
      w[3] = 16'h8001;
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      `CHK("ready", 1'b1, rdy)
      `CHK("lock", 8'hFF, lck)
      cmd(`PPP_CMD_ERASE);
      u_prog.wr(1'b0, 1'b0, busy);
      `CHK("erase busy", 1'b1, busy)
      cmd(`PPP_CMD_WR_PROG);
      for (i = 0; i < 4; i = i + 1) if (w[i] !== 16'hFFFF) begin
         adr(1'b0, 8'h30 + i[7:0]);
         dat(1'b0, w[i][7:0]);
         dat(1'b1, w[i][15:8]);
      end
      adr(1'b1, 8'h01);
      u_prog.wr(1'b0, 1'b0, busy);
      `CHK("page busy", 1'b1, busy)
      cmd(`PPP_CMD_NOP);
      cmd(`PPP_CMD_RD_PROG);
      for (i = 0; i < 4; i = i + 1) begin
         adr(1'b0, 8'h30 + i[7:0]);
         if (i == 1) u_prog.ld(`PPP_ACT_IDLE, 1'b0, 8'h20);
         u_prog.rd(1'b0, 1'b0, v);
         `CHK("prog lo", w[i][7:0], v)
         u_prog.rd(1'b1, 1'b0, v);
         `CHK("prog hi", w[i][15:8], v)
      end
      adr(1'b0, 8'h20);
      u_prog.rd(1'b0, 1'b0, v);
      `CHK("other page", 8'hFF, v)
      adr(1'b1, 8'h00);
      adr(1'b0, 8'h30);
      u_prog.rd(1'b0, 1'b0, v);
      `CHK("other window", 8'hFF, v)
      cmd(`PPP_CMD_WR_DATA);
      for (i = 0; i < 4; i = i + 1) begin
         adr(1'b0, 8'h04 + i[7:0]);
         dat(1'b0, 8'h10 + i[7:0]);
      end
      u_prog.wr(1'b1, 1'b0, busy);
      `CHK("data bs high", 1'b0, busy)
      u_prog.wr(1'b0, 1'b0, busy);
      `CHK("data busy", 1'b1, busy)
      cmd(`PPP_CMD_RD_DATA);
      for (i = 0; i < 4; i = i + 1) begin
         adr(1'b0, 8'h04 + i[7:0]);
         u_prog.rd(1'b0, 1'b0, v);
         `CHK("data", 8'h10 + i[7:0], v)
      end
      cmd(`PPP_CMD_WR_FUSE);
      dat(1'b0, 8'hBF);
      u_prog.wr(1'b1, 1'b0, busy);
      dat(1'b0, 8'hE4);
      u_prog.wr(1'b0, 1'b0, busy);
      dat(1'b0, 8'hFE);
      u_prog.wr(1'b0, 1'b1, busy);
      `CHK("fuse hi", 8'hBF, fhi)
      `CHK("fuse lo", 8'hE4, flo)
      `CHK("fuse ex", 8'hFE, fex)
      fx[0] = 8'hE4;
      fx[1] = 8'hFF;
      fx[2] = 8'hFE;
      fx[3] = 8'hBF;
      cmd(`PPP_CMD_RD_FUSE);
      for (i = 0; i < 4; i = i + 1) begin
         u_prog.rd(i[0], i[1], v);
         `CHK("fuse read", fx[i], v)
      end
      cmd(`PPP_CMD_WR_LOCK);
      dat(1'b0, 8'hFC);
      u_prog.wr(1'b0, 1'b0, busy);
      `CHK("lock mode", 8'hFC, lck)
      dat(1'b0, 8'h03);
      u_prog.wr(1'b0, 1'b0, busy);
      `CHK("boot lock refused", 8'h3C, lck)
      dat(1'b0, 8'hFF);
      u_prog.wr(1'b0, 1'b0, busy);
      `CHK("lock kept", 8'h3C, lck)
      cmd(`PPP_CMD_ERASE);
      u_prog.wr(1'b0, 1'b0, busy);
      `CHK("lock erased", 8'hFF, lck)
      `CHK("fuse kept", 8'hBF, fhi)
      cmd(`PPP_CMD_RD_DATA);
      adr(1'b0, 8'h04);
      u_prog.rd(1'b0, 1'b0, v);
      `CHK("data preserved", 8'h10, v)
      cmd(`PPP_CMD_RD_PROG);
      adr(1'b1, 8'h01);
      adr(1'b0, 8'h30);
      u_prog.rd(1'b0, 1'b0, v);
      `CHK("prog erased", 8'hFF, v)
      cmd(`PPP_CMD_RD_ID);
      adr(1'b1, 8'h00);
      fx[0] = 8'h6B;
      fx[1] = 8'h2D;
      fx[2] = 8'hE1;
      for (i = 0; i < 3; i = i + 1) begin
         adr(1'b0, i[7:0]);
         u_prog.rd(1'b0, 1'b0, v);
         `CHK("id", fx[i], v)
      end
      adr(1'b0, 8'h00);
      u_prog.rd(1'b1, 1'b0, v);
      `CHK("calibration", 8'h80, v)
      results;
   end
endmodule // ppp_port_tb

// [ppp_prog_model.sv]
// ppp_prog_model.sv - behavioural external programmer driving the port pins
// assumes one clock; all pins change just after a rising edge
`timescale 1ns/1ps
module ppp_prog_model (
   input wire sys_clk_i,
   input wire ready_busy_out_i,
   input wire dev_oe_i,
   input wire [7:0] dev_data_i,
   output reg strobe_o,
   output reg act_hi_o,
   output reg act_lo_o,
   output reg bs1_o,
   output reg bs2_o,
   output reg wr_n_o,
   output reg oe_n_o,
   output wire [7:0] bus_o
);
   reg [7:0] drv_r;
   // a released bus shows the inverse of the last byte, so stale data cannot pass
   assign bus_o = dev_oe_i ? dev_data_i : (oe_n_o ? drv_r : ~drv_r);
   initial begin
      strobe_o = 1'b0;
      act_hi_o = 1'b1;
      act_lo_o = 1'b1;
      bs1_o = 1'b0;
      bs2_o = 1'b0;
      wr_n_o = 1'b1;
      oe_n_o = 1'b1;
      drv_r = 8'h00;
   end

   // ==========================================================
   // load: action, byte select and byte set up one edge before the strobe
   task ld(input [1:0] act, input b1, input [7:0] v);
      begin
         @(posedge sys_clk_i);
         act_hi_o <= act[1];
         act_lo_o <= act[0];
         bs1_o <= b1;
         drv_r <= v;
         @(posedge sys_clk_i);
         strobe_o <= 1'b1;
         @(posedge sys_clk_i);
         strobe_o <= 1'b0;
      end
   endtask

   // ==========================================================
   // write pulse, then wait for ready; a refused write shows no busy at all
   task wr(input b1, input b2, output saw);
      integer n;
      begin
         saw = 1'b0;
         @(posedge sys_clk_i);
         bs1_o <= b1;
         bs2_o <= b2;
         @(posedge sys_clk_i);
         wr_n_o <= 1'b0;
         repeat (2) @(posedge sys_clk_i);
         wr_n_o <= 1'b1;
         for (n = 0; n < 5000 && (saw ? ready_busy_out_i !== 1'b1 : n < 4); n = n + 1) begin
            @(posedge sys_clk_i);
            if (ready_busy_out_i === 1'b0) saw = 1'b1;
         end
      end
   endtask

   // ==========================================================
   // read: output enable low, sample the bus three edges later
   task rd(input b1, input b2, output [7:0] v);
      begin
         @(posedge sys_clk_i);
         bs1_o <= b1;
         bs2_o <= b2;
         oe_n_o <= 1'b0;
         repeat (3) @(posedge sys_clk_i);
         v = bus_o;
         oe_n_o <= 1'b1;
      end
   endtask
endmodule // ppp_prog_model
